// File: src/susc_core.sv
/*
  Status and control logic of the universal serial unit: start, overflow
  and stop flags, collision bit, 4-bit transfer counter, wire modes,
  clock holds and pin drives.
  Assumes pins are asynchronous (two-stage synchronised here) and the CPU
  register port, timer overflow pulse and global enable are synchronous.
*/
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module susc_core
  import susc_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           rst,
  input  wire logic           clk_en,
  input  wire logic [0:0]     reg_addr,
  input  wire logic [7:0]     reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic      [7:0]     reg_rdata,
  input  wire logic [7:0]     shift_data_reg,
  input  wire logic           timer_zero_ovf,
  input  wire logic           global_irq_en,
  input  wire logic           deep_sleep,
  input  wire susc_pins_in_t  pins_in,
  output susc_pins_out_t      pins_out,
  output logic                start_irq,
  output logic                overflow_irq,
  output logic                wake_all,
  output logic                wake_idle,
  output logic                shift_clk
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0]     sda_s;
    logic [1:0]     scl_s;
    logic           sda_d;
    logic           scl_d;
    logic           start_cond_flag;
    logic           count_overflow_flag;
    logic           stop_cond_flag;
    logic [3:0]     transfer_count;
    logic           start_irq_enable;
    logic           overflow_irq_enable;
    susc_wire_t     wire_select;
    susc_csrc_t     clock_source_select;
    logic           clock_strobe_bit;
    logic           start_hold;
    logic           data_latch;
    logic [7:0]     rdata;
    susc_pins_out_t pins;
    logic           s_irq;
    logic           o_irq;
    logic           w_all;
    logic           w_idle;
    logic           sclk;
  } susc_state_t;

  susc_state_t st;
  susc_state_t next_st;

  logic sda_v;
  logic scl_v;
  logic scl_rise;
  logic scl_fall;
  logic sda_rise;
  logic sda_fall;
  logic two_wire;
  logic wr_stat;
  logic wr_ctrl;
  logic ext_src;
  logic cnt_tick;
  logic sr_tick;
  logic ovf_hold;

  // ==========================================================
  // combinational next state
  always_comb begin
    next_st = st;
    // second stage only is read by logic
    next_st.sda_s = {st.sda_s[0], pins_in.sda_in};
    next_st.scl_s = {st.scl_s[0], pins_in.scl_in};
    sda_v = st.sda_s[1];
    scl_v = st.scl_s[1];
    next_st.sda_d = sda_v;
    next_st.scl_d = scl_v;
    scl_rise = scl_v & ~st.scl_d;
    scl_fall = ~scl_v & st.scl_d;
    sda_rise = sda_v & ~st.sda_d;
    sda_fall = ~sda_v & st.sda_d;
    two_wire = st.wire_select[1];
    wr_stat  = reg_wr && (reg_addr == SUSC_ADDR_STATUS);
    wr_ctrl  = reg_wr && (reg_addr == SUSC_ADDR_CONTROL);
    ext_src  = st.clock_source_select[1];

    // counter and shift clock selection; inputs act in every mode
    cnt_tick = 1'b0;
    sr_tick  = 1'b0;
    if (ext_src) begin
      sr_tick = (st.clock_source_select == SUSC_CS_EXTP) ? scl_rise
                                                           : scl_fall;
      if (st.clock_strobe_bit) begin
        cnt_tick = wr_ctrl && reg_wdata[SUSC_CT_TC];
      end else begin
        cnt_tick = scl_rise | scl_fall;
      end
    end else if (st.clock_source_select == SUSC_CS_TIMER) begin
      cnt_tick = timer_zero_ovf;
      sr_tick  = timer_zero_ovf;
    end else begin
      cnt_tick = wr_ctrl && reg_wdata[SUSC_CT_CLK];
      sr_tick  = cnt_tick;
    end
    next_st.sclk = sr_tick;

    // counter: cpu load takes precedence over a tick in the same cycle
    if (wr_stat) begin
      next_st.transfer_count = reg_wdata[3:0];
    end else if (cnt_tick) begin
      next_st.transfer_count = st.transfer_count + SUSC_CNT_ONE;
    end

    // hold scl once the master pulls it low after a start; evaluated
    // before the clear so a same-cycle clear still releases the line
    if (two_wire && st.start_cond_flag && scl_fall) begin
      next_st.start_hold = 1'b1;
    end
    // write-one clears first, then start and stop sets win over the clear; overflow is never set in a status write cycle
    if (wr_stat && reg_wdata[SUSC_ST_START]) begin
      next_st.start_cond_flag = 1'b0;
      next_st.start_hold = 1'b0;
    end
    if (wr_stat && reg_wdata[SUSC_ST_OVF]) begin
      next_st.count_overflow_flag = 1'b0;
    end
    if (wr_stat && reg_wdata[SUSC_ST_STOP]) begin
      next_st.stop_cond_flag = 1'b0;
    end
    if (two_wire && sda_fall && scl_v) begin
      next_st.start_cond_flag = 1'b1;
    end
    if (!two_wire && st.clock_source_select[1] && !st.clock_strobe_bit
        && (scl_rise || scl_fall)) begin
      next_st.start_cond_flag = 1'b1;
    end
    if (two_wire && sda_rise && scl_v) begin
      next_st.stop_cond_flag = 1'b1;
    end
    if (cnt_tick && !wr_stat && st.transfer_count == SUSC_CNT_MAX) begin
      next_st.count_overflow_flag = 1'b1;
    end
    if (st.wire_select == SUSC_WM_OFF) begin
      next_st.start_hold = 1'b0;
    end

    // control register
    if (wr_ctrl) begin
      next_st.start_irq_enable    = reg_wdata[SUSC_CT_SIE];
      next_st.overflow_irq_enable = reg_wdata[SUSC_CT_OIE];
      next_st.wire_select =
        susc_wire_t'(reg_wdata[SUSC_CT_WM_HI:SUSC_CT_WM_LO]);
      next_st.clock_source_select =
        susc_csrc_t'(reg_wdata[SUSC_CT_CS_HI:SUSC_CT_CS_LO]);
      // strobe bit is a select only under external clocking
      next_st.clock_strobe_bit = reg_wdata[SUSC_CT_CS_HI]
                                 & reg_wdata[SUSC_CT_CLK];
    end

    // output latch transparent in first half of external clock
    if (!ext_src || (st.clock_source_select == SUSC_CS_EXTP ? !scl_v
                                                           : scl_v)) begin
      next_st.data_latch = shift_data_reg[SUSC_MSB];
    end

    // read data, one cycle after the strobe; control strobe bits read as zero
    next_st.rdata = SUSC_BYTE_ZERO;
    if (reg_rd && reg_addr == SUSC_ADDR_STATUS) begin
      next_st.rdata = {st.start_cond_flag, st.count_overflow_flag,
                       st.stop_cond_flag,
                       shift_data_reg[SUSC_MSB] ^ sda_v,
                       st.transfer_count};
    end else if (reg_rd && reg_addr == SUSC_ADDR_CONTROL) begin
      next_st.rdata = {st.start_irq_enable, st.overflow_irq_enable,
                       st.wire_select, st.clock_source_select,
                       2'h0};
    end

    // pin drives
    ovf_hold = (st.wire_select == SUSC_WM_TWO_H)
               && st.count_overflow_flag;
    next_st.pins.sda_out    = 1'b0;
    next_st.pins.scl_out    = 1'b0;
    next_st.pins.sda_oe_n   = 1'b1;
    next_st.pins.scl_oe_n   = 1'b1;
    next_st.pins.do_out     = pins_in.do_port;
    next_st.pins.do_oe_n    = ~pins_in.do_dir;
    next_st.pins.pullup_off = two_wire;
    if (st.wire_select == SUSC_WM_THREE) begin
      next_st.pins.do_out = st.data_latch;
    end else if (two_wire) begin
      next_st.pins.sda_oe_n = ~(pins_in.sda_dir
        && (!st.data_latch || !pins_in.sda_port));
      next_st.pins.scl_oe_n = ~(pins_in.scl_dir
        && (!pins_in.scl_port || st.start_hold || ovf_hold));
    end

    // interrupts and wake requests
    next_st.s_irq = st.start_cond_flag && st.start_irq_enable
                    && global_irq_en;
    next_st.o_irq = st.count_overflow_flag && st.overflow_irq_enable
                    && global_irq_en;
    next_st.w_all = next_st.s_irq;
    next_st.w_idle = next_st.o_irq && !deep_sleep;
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st <= '0;
      st.sda_s <= 2'h3;
      st.scl_s <= 2'h3;
      st.sda_d <= 1'b1;
      st.scl_d <= 1'b1;
      st.pins.sda_oe_n <= 1'b1;
      st.pins.scl_oe_n <= 1'b1;
      st.pins.do_oe_n  <= 1'b1;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign reg_rdata    = st.rdata;
  assign pins_out     = st.pins;
  assign start_irq    = st.s_irq;
  assign overflow_irq = st.o_irq;
  assign wake_all     = st.w_all;
  assign wake_idle    = st.w_idle;
  assign shift_clk    = st.sclk;

  // ==========================================================
  // checks
  property p_start_set;
    @(posedge core_clk) disable iff (rst)
      clk_en && two_wire && sda_fall && scl_v
      |=> st.start_cond_flag;
  endproperty
  a_start_set: assert property (p_start_set)
    else $error("start flag not set on start condition");

  property p_start_irq;
    @(posedge core_clk) disable iff (rst)
      clk_en && st.start_cond_flag && st.start_irq_enable && global_irq_en
      |=> start_irq;
  endproperty
  a_start_irq: assert property (p_start_irq)
    else $error("start irq missing");

  property p_start_clr;
    @(posedge core_clk) disable iff (rst)
      clk_en && wr_stat && reg_wdata[SUSC_ST_START] && !(two_wire && sda_fall
      && scl_v) && !(!two_wire && ext_src && !st.clock_strobe_bit
      && (scl_rise || scl_fall)) |=> !st.start_cond_flag && !st.start_hold;
  endproperty
  a_start_clr: assert property (p_start_clr)
    else $error("start flag clear failed");

  property p_wrap;
    @(posedge core_clk) disable iff (rst)
      clk_en && cnt_tick && !wr_stat && st.transfer_count == SUSC_CNT_MAX
      |=> st.count_overflow_flag && st.transfer_count == SUSC_CNT_ZERO;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("overflow not flagged on wrap");

  property p_ovf_irq;
    @(posedge core_clk) disable iff (rst)
      clk_en && !(st.count_overflow_flag && st.overflow_irq_enable
      && global_irq_en) |=> !overflow_irq;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq)
    else $error("spurious overflow irq");

  property p_wake_idle;
    @(posedge core_clk) disable iff (rst)
      $past(clk_en) && wake_idle |-> overflow_irq && $past(!deep_sleep);
  endproperty
  a_wake_idle: assert property (p_wake_idle)
    else $error("overflow wake from deep sleep");

  property p_load;
    @(posedge core_clk) disable iff (rst)
      clk_en && wr_stat |=> st.transfer_count == $past(reg_wdata[3:0]);
  endproperty
  a_load: assert property (p_load)
    else $error("counter load failed");

  property p_scl_hold;
    @(posedge core_clk) disable iff (rst)
      clk_en && ovf_hold && pins_in.scl_dir |=> !pins_out.scl_oe_n;
  endproperty
  a_scl_hold: assert property (p_scl_hold)
    else $error("scl not held on overflow");

  property p_off_mode;
    @(posedge core_clk) disable iff (rst)
      clk_en && st.wire_select == SUSC_WM_OFF
      |=> pins_out.sda_oe_n && pins_out.scl_oe_n && !st.start_hold;
  endproperty
  a_off_mode: assert property (p_off_mode)
    else $error("outputs active with mode zero");

  property p_stop_set;
    @(posedge core_clk) disable iff (rst)
      clk_en && two_wire && sda_rise && scl_v |=> st.stop_cond_flag;
  endproperty
  a_stop_set: assert property (p_stop_set)
    else $error("stop flag not set on stop condition");

  property p_pullup;
    @(posedge core_clk) disable iff (rst)
      clk_en && two_wire |=> pins_out.pullup_off;
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-ups left on in two-wire mode");

  property p_sda_drive;
    @(posedge core_clk) disable iff (rst)
      clk_en && two_wire && pins_in.sda_dir && !st.data_latch
      |=> !pins_out.sda_oe_n;
  endproperty
  a_sda_drive: assert property (p_sda_drive)
    else $error("sda not pulled low for a zero msb");

  property p_start_hold;
    @(posedge core_clk) disable iff (rst)
      clk_en && two_wire && st.start_hold && pins_in.scl_dir
      |=> !pins_out.scl_oe_n;
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("scl not held after start");

  property p_wake_all;
    @(posedge core_clk) disable iff (rst)
      clk_en && st.start_cond_flag && st.start_irq_enable && global_irq_en
      |=> wake_all;
  endproperty
  a_wake_all: assert property (p_wake_all)
    else $error("start irq gave no wake request");

  property p_ovf_clr;
    @(posedge core_clk) disable iff (rst)
      clk_en && wr_stat && reg_wdata[SUSC_ST_OVF]
      |=> !st.count_overflow_flag;
  endproperty
  a_ovf_clr: assert property (p_ovf_clr)
    else $error("overflow flag clear failed");

endmodule

// File: src/susc_pkg.sv
/*
  Package for the serial unit status/control block: register indices,
  field positions, wire modes and clock source codes.
  Assumes a single 200 MHz core clock domain.
*/
package susc_pkg;

  // register indices on the plain register port
  localparam logic [0:0] SUSC_ADDR_STATUS  = 1'h0;
  localparam logic [0:0] SUSC_ADDR_CONTROL = 1'h1;

  // status register fields
  localparam int SUSC_ST_START = 7;
  localparam int SUSC_ST_OVF   = 6;
  localparam int SUSC_ST_STOP  = 5;
  localparam int SUSC_ST_COLL  = 4;

  // control register fields
  localparam int SUSC_CT_SIE   = 7;
  localparam int SUSC_CT_OIE   = 6;
  localparam int SUSC_CT_WM_HI = 5;
  localparam int SUSC_CT_WM_LO = 4;
  localparam int SUSC_CT_CS_HI = 3;
  localparam int SUSC_CT_CS_LO = 2;
  localparam int SUSC_CT_CLK   = 1;
  localparam int SUSC_CT_TC    = 0;

  localparam logic [3:0] SUSC_CNT_MAX  = 4'hF;
  localparam logic [3:0] SUSC_CNT_ONE  = 4'h1;
  localparam logic [3:0] SUSC_CNT_ZERO = 4'h0;
  localparam logic [7:0] SUSC_BYTE_ZERO = 8'h00;
  localparam int         SUSC_MSB      = 7;

  typedef enum logic [1:0] {
    SUSC_WM_OFF   = 2'h0,
    SUSC_WM_THREE = 2'h1,
    SUSC_WM_TWO   = 2'h2,
    SUSC_WM_TWO_H = 2'h3
  } susc_wire_t;

  typedef enum logic [1:0] {
    SUSC_CS_SOFT  = 2'h0,
    SUSC_CS_TIMER = 2'h1,
    SUSC_CS_EXTP  = 2'h2,
    SUSC_CS_EXTN  = 2'h3
  } susc_csrc_t;

  // pins coming from the port logic and the outside lines
  typedef struct packed {
    logic sda_in;
    logic scl_in;
    logic sda_port;
    logic scl_port;
    logic sda_dir;
    logic scl_dir;
    logic do_port;
    logic do_dir;
  } susc_pins_in_t;

  // drives toward the pins; oe low means driven
  typedef struct packed {
    logic sda_out;
    logic sda_oe_n;
    logic scl_out;
    logic scl_oe_n;
    logic do_out;
    logic do_oe_n;
    logic pullup_off;
  } susc_pins_out_t;

endpackage

// File: testbench/serial_unit_status_control_tb.sv
/*
  Self-checking bench for the serial status/control core.
  Assumes the register port answers in the cycle after a read and that
  pin events appear within six core clock cycles.
*/
`timescale 1ns/100ps
module serial_unit_status_control_tb
  import susc_pkg::*;
;
  localparam logic [0:0] ST = SUSC_ADDR_STATUS;
  localparam logic [0:0] CT = SUSC_ADDR_CONTROL;
  logic           core_clk, rst, reg_wr, reg_rd, tz, gie, dsl, ce, sclk;
  logic [0:0]     reg_addr;
  logic [7:0]     reg_wdata, reg_rdata, sh, d;
  logic [5:0]     pb;
  logic           sda_line, scl_line, s_irq, o_irq, w_all, w_idle;
  susc_pins_in_t  pins_in;
  susc_pins_out_t po;
  int             failures, cmp_count, sc_n, sc_k;

  // port bits: sda_port, scl_port, sda_dir, scl_dir, do_port, do_dir
  assign pins_in = {sda_line, scl_line, pb};

  susc_core uut (.core_clk(core_clk), .rst(rst), .clk_en(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .shift_data_reg(sh),
    .timer_zero_ovf(tz), .global_irq_en(gie), .deep_sleep(dsl),
    .pins_in(pins_in), .pins_out(po), .start_irq(s_irq),
    .overflow_irq(o_irq), .wake_all(w_all), .wake_idle(w_idle),
    .shift_clk(sclk));

  // shift clock pulses seen so far
  always @(posedge core_clk) if (sclk) sc_n++;

  susc_peer peer (.sda_oe_n(po.sda_oe_n), .sda_out(po.sda_out),
    .scl_oe_n(po.scl_oe_n), .scl_out(po.scl_out),
    .sda_line(sda_line), .scl_line(scl_line));

  // ==========================================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [0:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [0:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t value %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic set_in(input logic [7:0] s, input logic [5:0] p,
                        input logic g, input logic ds);
    @(posedge core_clk);
    sh <= s; pb <= p; gie <= g; dsl <= ds;
    tick(3);
  endtask
  task automatic end_sim();
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd(ST, d); chk(d, 8'h00);
    rd(CT, d); chk(d, 8'h00);
    chk(po.scl_oe_n, 1'b1);
    set_in(8'h7F, 6'h3C, 1'b0, 1'b0);
    rd(ST, d); chk(d, 8'h10);
    set_in(8'hFF, 6'h3C, 1'b0, 1'b0);
  endtask

  task automatic t_count();
    wr(ST, 8'h1A); rd(ST, d); chk(d, 8'h0A);
    wr(CT, 8'h40); wr(ST, 8'h0E); wr(CT, 8'h42); wr(CT, 8'h42);
    rd(ST, d); chk(d, 8'h40);
    rd(CT, d); chk(d, 8'h40);
    tick(2); chk(o_irq, 1'b0);
    set_in(8'hFF, 6'h3C, 1'b1, 1'b0);
    chk(o_irq, 1'b1);
    chk(w_idle, 1'b1);
    set_in(8'hFF, 6'h3C, 1'b1, 1'b1);
    chk(w_idle, 1'b0);
    chk(w_all, 1'b0);
    set_in(8'hFF, 6'h3C, 1'b0, 1'b0);
    wr(ST, 8'h00); rd(ST, d); chk(d, 8'h40);
    wr(ST, 8'h40); rd(ST, d); chk(d, 8'h00);
    wr(CT, 8'h04);
    sc_k = sc_n;
    repeat (3) begin
      @(posedge core_clk) tz <= 1'b1;
      @(posedge core_clk) tz <= 1'b0;
    end
    rd(ST, d); chk(d, 8'h03);
    chk(8'(sc_n - sc_k), 8'h03);
  endtask

  task automatic t_ext();
    wr(ST, 8'hE0); wr(CT, 8'h08);
    peer.clocks(2); tick(6);
    rd(ST, d); chk(d, 8'h82);
    wr(CT, 8'h0A); wr(ST, 8'hE2);
    peer.clocks(2); tick(6);
    rd(ST, d); chk(d, 8'h02);
    wr(CT, 8'h0B); rd(ST, d); chk(d, 8'h03);
    wr(CT, 8'h0C);
    peer.clocks(2); tick(6);
    rd(ST, d); chk(d, 8'h85);
  endtask

  // sda pulses here also make start and stop events; later tests clear
  task automatic t_sda();
    wr(ST, 8'hE0); wr(CT, 8'h20); tick(3);
    chk(po.pullup_off, 1'b1);
    chk(po.sda_oe_n, 1'b1);
    set_in(8'h7F, 6'h3C, 1'b0, 1'b0);
    chk(po.sda_oe_n, 1'b0);
    set_in(8'hFF, 6'h1C, 1'b0, 1'b0);
    chk(po.sda_oe_n, 1'b0);
    set_in(8'hFF, 6'h3C, 1'b0, 1'b0);
  endtask

  task automatic t_start();
    wr(ST, 8'hE0); wr(CT, 8'hA0);
    peer.start_cond(); tick(6);
    rd(ST, d); chk(d, 8'h90);
    chk(s_irq, 1'b0);
    set_in(8'hFF, 6'h3C, 1'b1, 1'b0);
    chk(s_irq, 1'b1);
    set_in(8'hFF, 6'h3C, 1'b1, 1'b1);
    chk(w_all, 1'b1);
    set_in(8'hFF, 6'h3C, 1'b1, 1'b0);
    peer.clocks(1); tick(6);
    chk(po.scl_oe_n, 1'b0);
    peer.clocks(1); tick(6);
    chk(scl_line, 1'b0);
    wr(ST, 8'h80); tick(3);
    chk(po.scl_oe_n, 1'b1);
    chk(s_irq, 1'b0);
    peer.stop_cond(); tick(6);
    rd(ST, d); chk(d & 8'hE0, 8'h20);
    chk(s_irq, 1'b0);
    wr(ST, 8'h20); rd(ST, d); chk(d & 8'hE0, 8'h00);
    set_in(8'hFF, 6'h3C, 1'b0, 1'b0);
  endtask

  task automatic t_hold();
    wr(CT, 8'h30); wr(ST, 8'hEF); wr(CT, 8'h32); tick(3);
    chk(po.scl_oe_n, 1'b0);
    wr(ST, 8'h40); tick(3);
    chk(po.scl_oe_n, 1'b1);
    wr(CT, 8'h20); wr(ST, 8'hEF); wr(CT, 8'h22); tick(3);
    chk(po.scl_oe_n, 1'b1);
    wr(ST, 8'hE0);
  endtask

  task automatic t_three();
    wr(CT, 8'h10);
    set_in(8'h80, 6'h3D, 1'b0, 1'b0);
    chk(po.do_oe_n, 1'b0);
    chk(po.do_out, 1'b1);
    chk(po.pullup_off, 1'b0);
    set_in(8'h00, 6'h3D, 1'b0, 1'b0);
    chk(po.do_out, 1'b0);
    wr(CT, 8'h00);
    set_in(8'h80, 6'h3D, 1'b0, 1'b0);
    chk(po.do_out, 1'b0);
    chk(po.do_oe_n, 1'b0);
    chk(po.sda_oe_n, 1'b1);
  endtask

  // a write while the clock enable is low must leave no trace
  task automatic t_freeze();
    wr(ST, 8'h05);
    @(posedge core_clk) ce <= 1'b0;
    wr(ST, 8'h09);
    @(posedge core_clk) ce <= 1'b1;
    rd(ST, d); chk(d, 8'h05);
  endtask

  // ==========================================================
  // clock, sequence and watchdog
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 1'h0;
    reg_wdata = 8'h00; tz = 1'b0; gie = 1'b0; dsl = 1'b0;
    sh = 8'hFF; pb = 6'h3C; failures = 0; cmp_count = 0;
    ce = 1'b1; sc_n = 0; sc_k = 0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_reset(); t_count(); t_ext(); t_sda(); t_start(); t_hold();
    t_three(); t_freeze();
    end_sim();
  end

  // the whole run needs a few hundred cycles; this limit is generous
  initial begin
    #100000;
    failures++;
    end_sim();
  end
endmodule

// File: testbench/susc_peer.sv
/*
  Far-side model: a two-wire bus master that drives the serial data and
  clock lines. Its link clock runs at 125 ns per period and only inside
  the task that makes it.
  Assumes pull-ups on both lines and the device's registered drives.
*/
`timescale 1ns/100ps
module susc_peer (
  input  wire logic sda_oe_n,
  input  wire logic sda_out,
  input  wire logic scl_oe_n,
  input  wire logic scl_out,
  output logic      sda_line,
  output logic      scl_line
);
  logic sda_rel = 1'b1;
  logic scl_rel = 1'b1;

  // ==========================================================
  // wires
  // wired-and with pull-ups: any party pulling low wins
  assign sda_line = sda_rel & (sda_oe_n | sda_out);
  assign scl_line = scl_rel & (scl_oe_n | scl_out);

  // ==========================================================
  // bus actions
  // each call toggles the clock n times; it stands still between calls
  task automatic clocks(input int n);
    repeat (n) begin
      #62.5 scl_rel = ~scl_rel;
    end
  endtask

  task automatic start_cond();
    #62.5 sda_rel = 1'b0;
    #62.5;
  endtask

  // data goes low during clock low so that no start is seen first
  task automatic stop_cond();
    scl_rel = 1'b0;
    #62.5 sda_rel = 1'b0;
    #62.5 scl_rel = 1'b1;
    #62.5 sda_rel = 1'b1;
    #62.5;
  endtask
endmodule
